// ---- core/uei_pkg.sv ----
// constants and types for the usb error interrupt and control block
//
// Contract
// - enable bits 7,6,5 gate stuff, matrix, dma errors
// - enable bits 4,3 gate turnaround and size errors
// - enable bits 2,0 gate crc16 and pid errors
// - bit 1 gates crc5 (device) or eof (host)
// - enable bits 31..8 read zero, ignore writes
// - error irq reaches module flag only if master enabled
// - pointer reset bit forces pointers to even bank
// - device mode: bit 0 enables the module
// - host mode: bit 0 sends frame start every 1 ms
// - host logic reset on any host mode change
// - host mode: resume release appends low-speed eop
package uei_pkg;

  // clock and frame timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SOF_PERIOD_MS = 1;
  localparam int unsigned SOF_CYCLES = (SOF_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // register byte offsets on the 8-bit address window
  localparam logic [7:0] ERR_ENABLE_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h08;
  localparam logic [7:0] ERR_STATUS_OFS = 8'h0c;
  localparam logic [7:0] EVT_STATUS_OFS = 8'h10;
  localparam logic [7:0] EVT_MASK_OFS = 8'h14;

  // error enable / error status field positions
  localparam int unsigned ERR_W = 8;
  localparam int unsigned BIT_STUFF_POS = 7;
  localparam int unsigned BUS_MATRIX_POS = 6;
  localparam int unsigned DMA_POS = 5;
  localparam int unsigned TURNAROUND_POS = 4;
  localparam int unsigned FIELD_SIZE_POS = 3;
  localparam int unsigned CRC16_POS = 2;
  localparam int unsigned CRC5_EOF_POS = 1;
  localparam int unsigned PID_POS = 0;

  // control register field positions
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned MODULE_EN_POS = 0;
  localparam int unsigned PP_RESET_POS = 1;
  localparam int unsigned RESUME_POS = 2;
  localparam int unsigned HOST_MODE_POS = 3;
  localparam int unsigned TOKEN_BUSY_POS = 5;

  // general irq enable field
  localparam int unsigned ERR_MASTER_POS = 1;

  // event status field positions
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_SOF_POS = 0;
  localparam int unsigned EVT_HOST_RST_POS = 1;
  localparam int unsigned EVT_EOP_POS = 2;

  // reset values
  localparam logic [ERR_W-1:0] ERR_ENABLE_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CONTROL_RST = 4'h0;
  localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // write channel states, gray along idle -> one taken -> response
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_HAVE_AW = 2'b01,
    WS_RESP = 2'b11,
    WS_HAVE_W = 2'b10
  } uei_wstate_e;

endpackage

// ---- core/uei_flag_if.sv ----
// set, clear and state of a bank of sticky flags
`timescale 1ns/1ps
interface uei_flag_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;

  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ---- core/uei_sticky.sv ----
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module uei_sticky #(
  parameter int unsigned W = 8
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  uei_flag_if.owner f // flag bank
);
  logic [W-1:0] q_reg;

  // an event in the clearing cycle stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= (q_reg & ~f.clr) | f.set;
    end
  end

  assign f.q = q_reg;
endmodule // uei_sticky

// ---- core/uei_top.sv ----
// usb error interrupt gating and control register block, axi4-lite slave
`timescale 1ns/1ps
module uei_top
  import uei_pkg::*;
#(
  parameter int unsigned SOF_CYCLES_P = SOF_CYCLES
) (
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic bit_stuff_err_flag, // error pulse from link
  input wire logic bus_matrix_err_flag, // error pulse from bus side
  input wire logic dma_err_flag, // error pulse from dma
  input wire logic turnaround_timeout_err_flag, // error pulse from link
  input wire logic field_size_err_flag, // error pulse from link
  input wire logic crc16_fail_flag, // error pulse from link
  input wire logic crc5_err_flag, // error pulse, device mode
  input wire logic end_of_frame_err_flag, // error pulse, host mode
  input wire logic pid_check_err_flag, // error pulse from link
  input wire logic token_busy, // previous token still in work
  output logic usb_module_irq_flag, // error request to module irq
  output logic irq, // event interrupt, level
  output logic pingpong_pointer_reset, // hold pointers at even bank
  output logic module_enable, // device mode module enable
  output logic frame_start_token, // one-cycle frame start request
  output logic host_logic_reset, // one-cycle host logic reset
  output logic resume_drive, // drive resume signalling
  output logic ls_eop_append // one-cycle low-speed eop request
);

  // software visible state
  logic [ERR_W-1:0] err_enable_reg;
  logic [CTRL_W-1:0] control_reg;
  logic [1:0] irq_enable_reg;
  logic [EVT_W-1:0] evt_mask_reg;

  // axi channel state
  uei_wstate_e wr_state_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [7:0] awaddr_hold_reg;
  logic [31:0] wdata_hold_reg;
  logic [3:0] wstrb_hold_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // block outputs and internal timing
  logic mod_irq_reg;
  logic irq_reg;
  logic pp_reset_reg;
  logic module_en_reg;
  logic sof_reg;
  logic host_rst_reg;
  logic resume_reg;
  logic eop_reg;
  logic host_mode_prev_reg;
  logic resume_prev_reg;
  logic [15:0] sof_count_reg;

  // combinational helpers
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_commit;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic host_mode;
  logic sof_run;
  logic sof_hit;
  logic host_toggle;
  logic eop_fire;
  logic err_request;
  logic [31:0] rd_value;
  logic rd_mapped;

  // sticky banks for error flags and block events
  uei_flag_if #(.W(ERR_W)) err_bank ();
  uei_flag_if #(.W(EVT_W)) evt_bank ();

  uei_sticky #(.W(ERR_W)) u_err_sticky (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(err_bank.owner)
  );

  uei_sticky #(.W(EVT_W)) u_evt_sticky (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(evt_bank.owner)
  );

  assign host_mode = control_reg[HOST_MODE_POS];

  // handshakes and the write that lands this cycle
  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  assign ar_hs = s_axi_arvalid && arready_reg;
  assign wr_commit = ((wr_state_reg == WS_IDLE) && aw_hs && w_hs) ||
                     ((wr_state_reg == WS_HAVE_AW) && w_hs) ||
                     ((wr_state_reg == WS_HAVE_W) && aw_hs);
  assign wr_addr = (wr_state_reg == WS_HAVE_AW) ? awaddr_hold_reg : s_axi_awaddr;
  assign wr_data = (wr_state_reg == WS_HAVE_W) ? wdata_hold_reg : s_axi_wdata;
  assign wr_strb = (wr_state_reg == WS_HAVE_W) ? wstrb_hold_reg : s_axi_wstrb;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WS_IDLE;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_hold_reg <= 8'h00;
      wdata_hold_reg <= 32'h0000_0000;
      wstrb_hold_reg <= 4'h0;
    end else begin
      case (wr_state_reg)
        WS_IDLE: begin
          if (aw_hs && w_hs) begin
            wr_state_reg <= WS_RESP;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
          end else if (aw_hs) begin
            wr_state_reg <= WS_HAVE_AW;
            awready_reg <= 1'b0;
            awaddr_hold_reg <= s_axi_awaddr;
          end else if (w_hs) begin
            wr_state_reg <= WS_HAVE_W;
            wready_reg <= 1'b0;
            wdata_hold_reg <= s_axi_wdata;
            wstrb_hold_reg <= s_axi_wstrb;
          end
        end
        WS_HAVE_AW: begin
          if (w_hs) begin
            wr_state_reg <= WS_RESP;
            wready_reg <= 1'b0;
          end
        end
        WS_HAVE_W: begin
          if (aw_hs) begin
            wr_state_reg <= WS_RESP;
            awready_reg <= 1'b0;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= WS_IDLE;
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
          end
        end
        default: begin
          wr_state_reg <= WS_IDLE;
          awready_reg <= 1'b1;
          wready_reg <= 1'b1;
          bvalid_reg <= 1'b0;
        end
      endcase
      if (wr_commit) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_addr == ERR_ENABLE_OFS || wr_addr == CONTROL_OFS ||
                      wr_addr == IRQ_ENABLE_OFS || wr_addr == ERR_STATUS_OFS ||
                      wr_addr == EVT_STATUS_OFS || wr_addr == EVT_MASK_OFS) ?
                     RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // writable registers; every field sits in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_enable_reg <= ERR_ENABLE_RST;
      control_reg <= CONTROL_RST;
      irq_enable_reg <= IRQ_ENABLE_RST;
      evt_mask_reg <= EVT_MASK_RST;
    end else if (wr_commit && wr_strb[0]) begin
      case (wr_addr)
        ERR_ENABLE_OFS: err_enable_reg <= wr_data[ERR_W-1:0];
        CONTROL_OFS: control_reg <= wr_data[CTRL_W-1:0];
        IRQ_ENABLE_OFS: irq_enable_reg <= wr_data[1:0];
        EVT_MASK_OFS: evt_mask_reg <= wr_data[EVT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // read value; upper bits read zero, except token busy at bit 5 of control
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      ERR_ENABLE_OFS: rd_value[ERR_W-1:0] = err_enable_reg;
      CONTROL_OFS: begin
        rd_value[CTRL_W-1:0] = control_reg;
        rd_value[TOKEN_BUSY_POS] = token_busy;
      end
      IRQ_ENABLE_OFS: rd_value[1:0] = irq_enable_reg;
      ERR_STATUS_OFS: rd_value[ERR_W-1:0] = err_bank.q;
      EVT_STATUS_OFS: rd_value[EVT_W-1:0] = evt_bank.q;
      EVT_MASK_OFS: rd_value[EVT_W-1:0] = evt_mask_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // read channel: data follows one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // error flag capture; bit 1 source follows the mode
  assign err_bank.set[BIT_STUFF_POS] = bit_stuff_err_flag;
  assign err_bank.set[BUS_MATRIX_POS] = bus_matrix_err_flag;
  assign err_bank.set[DMA_POS] = dma_err_flag;
  assign err_bank.set[TURNAROUND_POS] = turnaround_timeout_err_flag;
  assign err_bank.set[FIELD_SIZE_POS] = field_size_err_flag;
  assign err_bank.set[CRC16_POS] = crc16_fail_flag;
  assign err_bank.set[CRC5_EOF_POS] = host_mode ? end_of_frame_err_flag : crc5_err_flag;
  assign err_bank.set[PID_POS] = pid_check_err_flag;

  // status banks clear on a read of their own register
  assign err_bank.clr = {ERR_W{ar_hs && (s_axi_araddr == ERR_STATUS_OFS)}};
  assign evt_bank.clr = {EVT_W{ar_hs && (s_axi_araddr == EVT_STATUS_OFS)}};

  // each flag with its own enable, checked every cycle
  assign err_request = |(err_bank.q & err_enable_reg);

  // module flag only with the error master enable set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_irq_reg <= 1'b0;
    end else begin
      mod_irq_reg <= err_request && irq_enable_reg[ERR_MASTER_POS];
    end
  end

  // level pointer reset and device-mode enable follow the control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_reset_reg <= 1'b0;
      module_en_reg <= 1'b0;
    end else begin
      pp_reset_reg <= control_reg[PP_RESET_POS];
      module_en_reg <= control_reg[MODULE_EN_POS] && !host_mode;
    end
  end

  // any change of the host mode bit, either way, resets host logic
  assign host_toggle = host_mode != host_mode_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_mode_prev_reg <= 1'b0;
      host_rst_reg <= 1'b0;
    end else begin
      host_mode_prev_reg <= host_mode;
      host_rst_reg <= host_toggle;
    end
  end

  // frame start timer; restarts on host reset so frames align to it
  assign sof_run = host_mode && control_reg[MODULE_EN_POS] && !host_toggle;
  assign sof_hit = sof_run && (sof_count_reg == 16'(SOF_CYCLES_P - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sof_count_reg <= 16'h0000;
      sof_reg <= 1'b0;
    end else begin
      sof_reg <= sof_hit;
      if (!sof_run || sof_hit) begin
        sof_count_reg <= 16'h0000;
      end else begin
        sof_count_reg <= sof_count_reg + 16'h0001;
      end
    end
  end

  // resume is driven as long as software holds the bit; timing is its job
  assign eop_fire = host_mode && resume_prev_reg && !control_reg[RESUME_POS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_prev_reg <= 1'b0;
      resume_reg <= 1'b0;
      eop_reg <= 1'b0;
    end else begin
      resume_prev_reg <= control_reg[RESUME_POS];
      resume_reg <= control_reg[RESUME_POS];
      eop_reg <= eop_fire;
    end
  end

  // block events raise sticky bits; the event mask gates only the irq
  assign evt_bank.set[EVT_SOF_POS] = sof_hit;
  assign evt_bank.set[EVT_HOST_RST_POS] = host_toggle;
  assign evt_bank.set[EVT_EOP_POS] = eop_fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_bank.q & evt_mask_reg);
    end
  end

  // port drive, all from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign usb_module_irq_flag = mod_irq_reg;
  assign irq = irq_reg;
  assign pingpong_pointer_reset = pp_reset_reg;
  assign module_enable = module_en_reg;
  assign frame_start_token = sof_reg;
  assign host_logic_reset = host_rst_reg;
  assign resume_drive = resume_reg;
  assign ls_eop_append = eop_reg;

endmodule // uei_top

// ---- verif/uei_chk_sva.sv ----
// port-level assertions for the usb error irq and control block
`timescale 1ns/1ps
module uei_chk
  import uei_pkg::*;
#(
  parameter int unsigned SOF_CYCLES_P = SOF_CYCLES
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // b valid
  input wire logic bit_stuff_err_flag, // error line
  input wire logic bus_matrix_err_flag, // error line
  input wire logic dma_err_flag, // error line
  input wire logic turnaround_timeout_err_flag, // error line
  input wire logic field_size_err_flag, // error line
  input wire logic crc16_fail_flag, // error line
  input wire logic crc5_err_flag, // error line, device
  input wire logic end_of_frame_err_flag, // error line, host
  input wire logic pid_check_err_flag, // error line
  input wire logic usb_module_irq_flag, // error request
  input wire logic pingpong_pointer_reset, // pointer reset
  input wire logic module_enable, // module enable
  input wire logic frame_start_token, // frame start pulse
  input wire logic host_logic_reset, // host reset pulse
  input wire logic ls_eop_append // eop pulse
);
  logic [7:0] a_q;
  logic [31:0] d_q;
  logic bv_q;
  logic [3:0] sh_ctrl;
  logic [7:0] sh_ee;
  logic sh_me;
  logic [31:0] gap;
  logic armed;
  logic [7:0] fl;

  // shadow registers, committed as the response rises, one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      sh_ctrl <= 4'h0;
      sh_ee <= 8'h00;
      sh_me <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata;
      if (s_axi_bvalid && !bv_q && s_axi_bresp == RESP_OKAY) begin
        if (a_q == CONTROL_OFS) sh_ctrl <= d_q[3:0];
        if (a_q == ERR_ENABLE_OFS) sh_ee <= d_q[7:0];
        if (a_q == IRQ_ENABLE_OFS) sh_me <= d_q[ERR_MASTER_POS];
      end
    end
  end

  // cycles since the last frame start, armed only across an unbroken run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 32'h0;
      armed <= 1'b0;
    end else begin
      gap <= frame_start_token ? 32'h0 : gap + 32'h1;
      armed <= frame_start_token || (armed && sh_ctrl[0] && sh_ctrl[3]);
    end
  end

  // bit 1 source follows the mode
  assign fl = {bit_stuff_err_flag, bus_matrix_err_flag, dma_err_flag,
    turnaround_timeout_err_flag, field_size_err_flag, crc16_fail_flag,
    (sh_ctrl[HOST_MODE_POS] ? end_of_frame_err_flag : crc5_err_flag), pid_check_err_flag};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence resume_release;
    $fell(sh_ctrl[RESUME_POS]) && sh_ctrl[HOST_MODE_POS];
  endsequence
  sequence host_flip;
    sh_ctrl[HOST_MODE_POS] != $past(sh_ctrl[HOST_MODE_POS]);
  endsequence

  pp_follow_a: assert property (pingpong_pointer_reset == sh_ctrl[PP_RESET_POS])
    else $error("pointer reset does not follow control");
  mod_enable_a: assert property (module_enable == (sh_ctrl[0] && !sh_ctrl[3]))
    else $error("module enable wrong for mode");
  host_rst_a: assert property (host_flip |-> host_logic_reset)
    else $error("no host reset on mode change");
  host_rst_only_a: assert property (host_logic_reset |-> host_flip)
    else $error("host reset without mode change");
  eop_pulse_a: assert property (resume_release |-> ls_eop_append)
    else $error("no eop after host resume release");
  eop_only_a: assert property (ls_eop_append |-> resume_release)
    else $error("eop without host resume release");
  sof_gap_a: assert property (frame_start_token && armed |-> gap == SOF_CYCLES_P - 1)
    else $error("frame start period wrong");
  sof_gate_a: assert property (frame_start_token |-> sh_ctrl[0] && sh_ctrl[3])
    else $error("frame start outside host enable");
  err_raise_a: assert property ((|(fl & sh_ee)) && sh_me |-> ##[1:3] usb_module_irq_flag)
    else $error("enabled error did not raise request");
  err_gate_a: assert property ($rose(usb_module_irq_flag) |-> sh_me && sh_ee != 8'h00)
    else $error("error request without enables");
endmodule // uei_chk

bind uei_top uei_chk #(.SOF_CYCLES_P(SOF_CYCLES_P)) i_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .bit_stuff_err_flag, .bus_matrix_err_flag, .dma_err_flag,
  .turnaround_timeout_err_flag, .field_size_err_flag, .crc16_fail_flag, .crc5_err_flag,
  .end_of_frame_err_flag, .pid_check_err_flag, .usb_module_irq_flag, .pingpong_pointer_reset,
  .module_enable, .frame_start_token, .host_logic_reset, .ls_eop_append);

// ---- verif/uei_link_model.sv ----
// link-side model raising error lines and token busy
`timescale 1ns/1ps
module uei_link_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [8:0] inject, // one-cycle error requests, bit 8 eof
  input wire logic busy_req, // token still in work
  output logic [8:0] err_flags, // error lines, bit 8 eof
  output logic token_busy // busy seen by the block
);
  // single-cycle error pulses, the hardest case for sticky capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flags <= 9'h000;
      token_busy <= 1'b0;
    end else begin
      err_flags <= inject;
      token_busy <= busy_req;
    end
  end
endmodule // uei_link_model

// ---- verif/testbench.sv ----
// self-checking bench for the usb error irq and control block
`timescale 1ns/1ps
module testbench;
  import uei_pkg::*;
  localparam int P = 16; // short frame period
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic usb_module_irq_flag, irq, pingpong_pointer_reset, module_enable;
  logic frame_start_token, host_logic_reset, resume_drive, ls_eop_append;
  logic [8:0] inject = 9'h000;
  logic [8:0] ef;
  logic busy_req = 1'b0;
  logic token_busy;
  int bad_count = 0;
  int check_count = 0;
  int sof_cnt = 0, hr_cnt = 0, eop_cnt = 0, gap = 0, last_gap = 0;

  always #12.5 aclk = ~aclk;

  uei_top #(.SOF_CYCLES_P(P)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_stuff_err_flag(ef[7]),
    .bus_matrix_err_flag(ef[6]), .dma_err_flag(ef[5]), .turnaround_timeout_err_flag(ef[4]),
    .field_size_err_flag(ef[3]), .crc16_fail_flag(ef[2]), .crc5_err_flag(ef[1]),
    .end_of_frame_err_flag(ef[8]), .pid_check_err_flag(ef[0]), .token_busy,
    .usb_module_irq_flag, .irq, .pingpong_pointer_reset, .module_enable, .frame_start_token,
    .host_logic_reset, .resume_drive, .ls_eop_append);

  uei_link_model i_link (.aclk, .aresetn, .inject, .busy_req, .err_flags(ef), .token_busy);

  // one-cycle outputs counted here, judged by the scenarios
  always @(posedge aclk) begin
    gap <= gap + 1;
    if (frame_start_token === 1'b1) begin
      sof_cnt <= sof_cnt + 1;
      last_gap <= gap + 1;
      gap <= 0;
    end
    if (host_logic_reset === 1'b1) hr_cnt <= hr_cnt + 1;
    if (ls_eop_append === 1'b1) eop_cnt <= eop_cnt + 1;
  end

  task test_done;
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er, "write response");
    cmp(n < 40, 1'b1, "write timeout");
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rresp, er, "read response");
    cmp(n < 40, 1'b1, "read timeout");
    cmp(s_axi_rdata, e, "read data");
  endtask

  task pulse_err(input logic [8:0] v);
    @(posedge aclk);
    inject <= v;
    @(posedge aclk);
    inject <= 9'h000;
    repeat (4) @(posedge aclk);
  endtask

  task t_regs;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    wr(ERR_ENABLE_OFS, 32'hffff_ffff);
    rd(ERR_ENABLE_OFS, 32'h0000_00ff);
    busy_req <= 1'b1;
    rd(CONTROL_OFS, 32'h20);
    busy_req <= 1'b0;
  endtask

  task t_gate;
    int n;
    wr(IRQ_ENABLE_OFS, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(ERR_ENABLE_OFS, 32'h1 << i);
      pulse_err({1'b1, ~(8'h01 << i)});
      cmp(usb_module_irq_flag, 1'b0, "masked error raised request");
      rd(ERR_STATUS_OFS, {24'h0, ~(8'h01 << i)});
      pulse_err({1'b0, 8'h01 << i});
      cmp(usb_module_irq_flag, 1'b1, "enabled error lost");
      rd(ERR_STATUS_OFS, 32'h1 << i);
      repeat (3) @(posedge aclk);
      cmp(usb_module_irq_flag, 1'b0, "request held after clear");
    end
    wr(ERR_ENABLE_OFS, 32'hff);
    wr(IRQ_ENABLE_OFS, 32'h1);
    pulse_err(9'h0ff);
    cmp(usb_module_irq_flag, 1'b0, "request without master enable");
    wr(IRQ_ENABLE_OFS, 32'h2);
    repeat (3) @(posedge aclk);
    cmp(usb_module_irq_flag, 1'b1, "master enable ignored");
    rd(ERR_STATUS_OFS, 32'hff);
    n = hr_cnt;
    wr(CONTROL_OFS, 32'h8);
    pulse_err(9'h002);
    cmp(usb_module_irq_flag, 1'b0, "crc5 taken in host mode");
    pulse_err(9'h100);
    cmp(usb_module_irq_flag, 1'b1, "eof lost in host mode");
    rd(ERR_STATUS_OFS, 32'h2);
    wr(CONTROL_OFS, 32'h0);
    repeat (3) @(posedge aclk);
    cmp(hr_cnt, n + 2, "host logic reset count");
  endtask

  task t_ctrl;
    wr(CONTROL_OFS, 32'h3);
    @(posedge aclk);
    cmp(pingpong_pointer_reset, 1'b1, "pointer reset not held");
    cmp(module_enable, 1'b1, "module not enabled");
    wr(CONTROL_OFS, 32'hb);
    @(posedge aclk);
    cmp(module_enable, 1'b0, "module enabled in host mode");
    wr(CONTROL_OFS, 32'h1);
    @(posedge aclk);
    cmp(pingpong_pointer_reset, 1'b0, "pointer reset stuck");
    wr(CONTROL_OFS, 32'h0);
    @(posedge aclk);
    cmp(module_enable, 1'b0, "module not disabled");
  endtask

  task t_sof;
    int n;
    rd(EVT_STATUS_OFS, 32'h2);
    wr(EVT_MASK_OFS, 32'h1);
    n = sof_cnt;
    wr(CONTROL_OFS, 32'h9);
    repeat (3 * P + 4) @(posedge aclk);
    cmp(sof_cnt, n + 3, "frame start count");
    cmp(last_gap, P, "frame start period");
    cmp(irq, 1'b1, "frame event irq missing");
    rd(EVT_STATUS_OFS, 32'h3);
    wr(CONTROL_OFS, 32'h8);
    n = sof_cnt;
    repeat (2 * P) @(posedge aclk);
    cmp(sof_cnt, n, "frame start while disabled");
    cmp(irq, 1'b0, "irq held after read");
    wr(EVT_MASK_OFS, 32'h0);
    wr(CONTROL_OFS, 32'h0);
    repeat (3) @(posedge aclk);
    cmp(irq, 1'b0, "masked event raised irq");
    rd(EVT_STATUS_OFS, 32'h2);
  endtask

  task t_resume;
    int n;
    wr(CONTROL_OFS, 32'hc);
    @(posedge aclk);
    cmp(resume_drive, 1'b1, "resume not driven");
    n = eop_cnt;
    wr(CONTROL_OFS, 32'h8);
    repeat (4) @(posedge aclk);
    cmp(eop_cnt, n + 1, "no eop on host resume release");
    cmp(resume_drive, 1'b0, "resume still driven");
    rd(EVT_STATUS_OFS, 32'h6);
    wr(CONTROL_OFS, 32'h4);
    wr(CONTROL_OFS, 32'h0);
    repeat (4) @(posedge aclk);
    cmp(eop_cnt, n + 1, "eop appended in device mode");
  endtask

  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_gate;
    t_ctrl;
    t_sof;
    t_resume;
    test_done;
  end

  // watchdog far beyond the few hundred cycles needed
  initial begin
    #(25 * 20000);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done;
  end
endmodule // testbench
